// ---- src/ccg_pkg.sv ----
// Shared constants and types for the CPU clock generator and bus cycle timer
package ccg_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_RSTCFG = 8'h00;
	localparam logic [7:0] ADDR_BUSCFG = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CLKSEL_MSB = 7;
	localparam int CFG_W = 8;
	localparam logic [7:0] RSTCFG_RST = 8'h00;
	localparam int MCTC_LO = 0;
	localparam int MCTC_W = 4;
	localparam int RWDLY_BIT = 4;
	localparam int MTTC_BIT = 5;
	localparam int ALECTL_BIT = 6;
	localparam int BUSCFG_W = 7;
	localparam logic [6:0] BUSCFG_RST = 7'h00;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_WRITE_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_CLK_BIT = 1;
	localparam int ST_DIV_BIT = 2;
	localparam int ST_LEN_LO = 8;
	localparam int ST_CNT_LO = 16;

	// ****************************************
	// Bus cycle timing in clock phases
	// ****************************************
	localparam int PH_W = 8;
	localparam logic [7:0] BASE_PHASES = 8'h06;
	localparam logic [7:0] ALE_BASE = 8'h01;
	localparam logic [7:0] STROBE_BASE = 8'h01;
	localparam logic [7:0] STROBE_LEN = 8'h03;
	localparam logic [3:0] MCTC_MAX = 4'hF;
	localparam logic [0:0] MTTC_MAX = 1'h1;

	typedef enum logic {CCG_IDLE, CCG_RUN} ccg_seq_e;
endpackage

// ---- src/ccg_bus_seq.sv ----
// External memory cycle sequencer stepping on CPU clock phases
`timescale 1ns/1ps
module ccg_bus_seq
	import ccg_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Phase step and request
	input wire logic phase_step,
	input wire logic start,
	input wire logic start_write,
	input wire logic [BUSCFG_W-1:0] bus_region_config,
	// Bus strobes
	output logic ale_r,
	output logic rd_n_r,
	output logic wr_n_r,
	output logic done_r,
	// Status
	output logic busy,
	output logic [PH_W-1:0] len_r
);
	ccg_seq_e state_r;
	logic [PH_W-1:0] cnt_r, ale_end_r, s_r, e_r;
	logic write_r, dly_r;
	logic [PH_W-1:0] a, d, c, f, cnt_nxt;

	always_comb begin
		a = {7'h00, bus_region_config[ALECTL_BIT]};
		d = {7'h00, bus_region_config[RWDLY_BIT]};
		c = {3'h0, MCTC_MAX - bus_region_config[MCTC_LO +: MCTC_W], 1'b0};
		f = {6'h00, MTTC_MAX - bus_region_config[MTTC_BIT], 1'b0};
		cnt_nxt = cnt_r + 8'h01;
	end

	assign busy = (state_r == CCG_RUN);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= CCG_IDLE;
			cnt_r <= '0;
			ale_end_r <= '0;
			s_r <= '0;
			e_r <= '0;
			len_r <= '0;
			write_r <= 1'b0;
			dly_r <= 1'b0;
			ale_r <= 1'b0;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			unique case (state_r)
				CCG_IDLE: begin
					if (start) begin
						state_r <= CCG_RUN;
						cnt_r <= '0;
						write_r <= start_write;
						// Kept so the strobe check does not depend on later config writes
						dly_r <= bus_region_config[RWDLY_BIT];
						ale_r <= 1'b1;
						ale_end_r <= ALE_BASE + a;
						s_r <= STROBE_BASE + a + a + d;
						e_r <= STROBE_BASE + STROBE_LEN + a + a + c;
						len_r <= BASE_PHASES + a + a + c + f;
					end
				end
				CCG_RUN: begin
					// Every phase edge is a step, so both CPU clock edges schedule work
					if (phase_step) begin
						cnt_r <= cnt_nxt;
						ale_r <= (cnt_nxt < ale_end_r);
						rd_n_r <= !(!write_r && cnt_nxt >= s_r && cnt_nxt < e_r);
						wr_n_r <= !(write_r && cnt_nxt >= s_r && cnt_nxt < e_r);
						if (cnt_nxt == len_r) begin
							state_r <= CCG_IDLE;
							done_r <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_len_calc: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == CCG_IDLE && start) |=> len_r == BASE_PHASES
		+ 8'h02 * {7'h00, $past(bus_region_config[ALECTL_BIT])}
		+ 8'h02 * ({4'h0, MCTC_MAX} - {4'h0, $past(bus_region_config[MCTC_LO +: MCTC_W])})
		+ 8'h02 * ({7'h00, MTTC_MAX} - {7'h00, $past(bus_region_config[MTTC_BIT])}))
		else $error("Bus cycle length wrong");
	a_cycle_end: assert property (@(posedge aclk) disable iff (!aresetn)
		(busy && phase_step && cnt_nxt == len_r) |=> (done_r && !busy && cnt_r == len_r))
		else $error("Bus cycle did not end at its length");
	a_ale_fall: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(ale_r) |-> (cnt_r == ale_end_r))
		else $error("ALE fell at wrong phase");
	a_strobe_start: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(rd_n_r && wr_n_r) |-> (busy && cnt_r == s_r
		&& s_r == ale_end_r + ale_end_r - 8'h01 + {7'h00, dly_r}))
		else $error("Strobe started at wrong phase");
endmodule

// ---- src/ccg_top.sv ----
// CPU clock generator with reset configuration latch and bus cycle timer
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ccg_top
	import ccg_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins
	input wire logic oscillator_input_pin,
	input wire logic long_reset_pin,
	input wire logic [CFG_W-1:0] upper_port0_pins,
	// Clock outputs
	output logic cpu_clk,
	output logic phase_pulse,
	// External bus strobes
	output logic ale,
	output logic rd_n,
	output logic wr_n,
	output logic bus_done,
	// AXI4-Lite write address
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic osc_s1_r, osc_s2_r, osc_s3_r;
	logic lrst_s1_r, lrst_s2_r;
	logic [CFG_W-1:0] p0h_s1_r, p0h_s2_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
			lrst_s1_r <= 1'b0;
			lrst_s2_r <= 1'b0;
			p0h_s1_r <= '0;
			p0h_s2_r <= '0;
		end else begin
			osc_s1_r <= oscillator_input_pin;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
			lrst_s1_r <= long_reset_pin;
			lrst_s2_r <= lrst_s1_r;
			p0h_s1_r <= upper_port0_pins;
			p0h_s2_r <= p0h_s1_r;
		end
	end

	// ****************************************
	// Reset configuration latch
	// ****************************************
	logic [CFG_W-1:0] reset_config_latch_r;
	logic div_mode;

	// Follows the pins for as long as the long reset stands, then holds
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_config_latch_r <= RSTCFG_RST;
		end else if (lrst_s2_r) begin
			reset_config_latch_r <= p0h_s2_r;
		end
	end

	assign div_mode = reset_config_latch_r[CLKSEL_MSB];

	// ****************************************
	// CPU clock generation
	// ****************************************
	logic osc_rise, cpu_clk_nxt, cpu_clk_r, phase_pulse_r;

	assign osc_rise = osc_s2_r && !osc_s3_r;

	always_comb begin
		if (div_mode) begin
			// Toggling on rising edges only makes each phase one full period
			cpu_clk_nxt = osc_rise ? !cpu_clk_r : cpu_clk_r;
		end else begin
			cpu_clk_nxt = osc_s2_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_clk_r <= 1'b0;
			phase_pulse_r <= 1'b0;
		end else begin
			cpu_clk_r <= cpu_clk_nxt;
			phase_pulse_r <= (cpu_clk_nxt != cpu_clk_r);
		end
	end

	assign cpu_clk = cpu_clk_r;
	assign phase_pulse = phase_pulse_r;

	// ****************************************
	// Register bus slave
	// ****************************************
	logic [BUSCFG_W-1:0] bus_region_config_r;
	logic [15:0] cyc_cnt_r;
	logic aw_got_r, w_got_r, aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic do_write, start_req, seq_busy, seq_done;
	logic [PH_W-1:0] seq_len;

	assign do_write = aw_got_r && w_got_r && !bvalid_r;
	assign start_req = do_write && awaddr_r == ADDR_CTRL && wstrb_r[0]
		&& wdata_r[CTRL_START_BIT];

	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		if (awvalid && awready_r) aw_got_nxt = 1'b1;
		else if (do_write) aw_got_nxt = 1'b0;
		if (wvalid && wready_r) w_got_nxt = 1'b1;
		else if (do_write) w_got_nxt = 1'b0;
		bvalid_nxt = do_write || (bvalid_r && !bready);
		rvalid_nxt = (arvalid && arready_r) || (rvalid_r && !rready);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awready_r <= !aw_got_nxt && !bvalid_nxt;
			wready_r <= !w_got_nxt && !bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			if (awvalid && awready_r) awaddr_r <= awaddr;
			if (wvalid && wready_r) begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (do_write) begin
				bresp_r <= (awaddr_r == ADDR_BUSCFG || awaddr_r == ADDR_CTRL
					|| awaddr_r == ADDR_RSTCFG || awaddr_r == ADDR_STATUS)
					? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_region_config_r <= BUSCFG_RST;
		end else if (do_write && awaddr_r == ADDR_BUSCFG && wstrb_r[0]) begin
			bus_region_config_r <= wdata_r[BUSCFG_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_cnt_r <= '0;
		end else if (seq_done) begin
			cyc_cnt_r <= cyc_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			arready_r <= !rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (arvalid && arready_r) begin
				rresp_r <= RESP_OKAY;
				rdata_r <= '0;
				unique case (araddr)
					ADDR_RSTCFG: rdata_r[CFG_W-1:0] <= reset_config_latch_r;
					ADDR_BUSCFG: rdata_r[BUSCFG_W-1:0] <= bus_region_config_r;
					ADDR_CTRL: rdata_r[ST_BUSY_BIT] <= seq_busy;
					ADDR_STATUS: begin
						rdata_r[ST_BUSY_BIT] <= seq_busy;
						rdata_r[ST_CLK_BIT] <= cpu_clk_r;
						rdata_r[ST_DIV_BIT] <= div_mode;
						rdata_r[ST_LEN_LO +: PH_W] <= seq_len;
						rdata_r[ST_CNT_LO +: 16] <= cyc_cnt_r;
					end
					default: rresp_r <= RESP_SLVERR;
				endcase
			end
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// ****************************************
	// Bus cycle sequencer
	// ****************************************
	ccg_bus_seq u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.phase_step(phase_pulse_r),
		.start(start_req),
		.start_write(wdata_r[CTRL_WRITE_BIT]),
		.bus_region_config(bus_region_config_r),
		.ale_r(ale),
		.rd_n_r(rd_n),
		.wr_n_r(wr_n),
		.done_r(seq_done),
		.busy(seq_busy),
		.len_r(seq_len)
	);

	assign bus_done = seq_done;

	// ****************************************
	// Checks
	// ****************************************
	a_latch_capture: assert property (@(posedge aclk) disable iff (!aresetn)
		lrst_s2_r |=> reset_config_latch_r[7:5] == $past(p0h_s2_r[7:5]))
		else $error("Clock select not captured");
	a_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(!lrst_s2_r && $past(aresetn)) |=> $stable(reset_config_latch_r))
		else $error("Latch changed outside long reset");
	a_div_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
		(div_mode && osc_rise && $stable(div_mode)) |=> cpu_clk_r != $past(cpu_clk_r))
		else $error("Divided clock missed a toggle");
	a_div_steady: assert property (@(posedge aclk) disable iff (!aresetn)
		(div_mode && !osc_rise) |=> cpu_clk_r == $past(cpu_clk_r))
		else $error("Divided clock moved off a rising edge");
	a_direct_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		(!div_mode && $rose(osc_s2_r)) |=> cpu_clk_r ##1 (cpu_clk_r == osc_s3_r))
		else $error("Direct clock does not follow input");
	a_phase_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(cpu_clk_r) || $fell(cpu_clk_r)) |-> phase_pulse_r)
		else $error("Clock edge without phase step");
endmodule

// ---- verif/ccg_osc_model.sv ----
// Oscillator partner driving the clock input pin with set high and low times
`timescale 1ns/1ps
module ccg_osc_model (
	// Shape
	input wire logic [7:0] hi_ns,
	input wire logic [7:0] lo_ns,
	// Clock out
	output logic osc
);
	// Odd start offset keeps pin edges away from the system clock edges
	initial begin
		osc = 1'b0;
		#3;
		forever begin
			osc = 1'b1;
			#(hi_ns);
			osc = 1'b0;
			#(lo_ns);
		end
	end
endmodule

// ---- verif/cpu_clock_gen_bus_cycle_timing_test.sv ----
// Self-checking bench for the CPU clock generator and bus cycle timer
`timescale 1ns/1ps
module cpu_clock_gen_bus_cycle_timing_test import ccg_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic osc;
	logic long_reset_pin = 1'b0;
	logic [7:0] pins = 8'h00;
	logic cpu_clk, phase_pulse, ale, rd_n, wr_n, bus_done;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000, rdata, d;
	logic awready, wready, bvalid, arready, rvalid, prv = 1'b0, ale_q = 1'b0, stb_q = 1'b1;
	logic wlow, wrt;
	logic [1:0] bresp, rresp, r;
	logic [7:0] pv;
	logic [6:0] cfg;
	logic [3:0] w;
	int err_count = 0, n_compared = 0, cyc = 0, seed = 32'h22f3;
	int run = 0, n = 0, na = 0, ns = 0, nd = 0, nr = 0, total = 0, base = 0;
	int len_q[$];
	int lvl_q[$];

	ccg_osc_model osc_u (.hi_ns(8'h1E), .lo_ns(8'h32), .osc(osc));

	ccg_top dut_u (.aclk(aclk), .aresetn(aresetn), .oscillator_input_pin(osc),
		.long_reset_pin(long_reset_pin), .upper_port0_pins(pins), .cpu_clk(cpu_clk),
		.phase_pulse(phase_pulse), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .bus_done(bus_done),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	always #5 aclk = ~aclk;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		chk(32'(bresp), 32'(RESP_OKAY), "write response");
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rready <= 1'b0;
		v = rdata;
		rs = rresp;
	endtask

	// ****************************************
	// Clock and bus monitors
	// ****************************************
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			wrap_up();
		end
		if (aresetn === 1'b1) chk(32'(phase_pulse), 32'(cpu_clk !== prv), "phase pulse");
		if (cpu_clk !== prv) begin
			lvl_q.push_back(int'(prv));
			len_q.push_back(run);
			run = 1;
		end else begin
			run++;
		end
		prv = cpu_clk;
		if (phase_pulse === 1'b1) n++;
		if (ale_q === 1'b1 && ale === 1'b0) na = n;
		if (stb_q === 1'b1 && (rd_n & wr_n) === 1'b0) begin
			ns = n;
			wlow = ~wr_n;
		end
		if (stb_q === 1'b0 && (rd_n & wr_n) === 1'b1) nr = n;
		if (bus_done === 1'b1) nd = n;
		ale_q = ale;
		stb_q = rd_n & wr_n;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_RSTCFG, d, r);
		chk(d, 32'(RSTCFG_RST), "latch reset");
		rd(8'h40, d, r);
		chk(32'(r), 32'(RESP_SLVERR), "unmapped");
		$display("test reset and map done");
		for (int m = 0; m < 2; m++) begin
			pv = 8'($random(seed));
			pv[7] = m[0];
			pins <= pv;
			long_reset_pin <= 1'b1;
			repeat (8) @(posedge aclk);
			long_reset_pin <= 1'b0;
			repeat (4) @(posedge aclk);
			pins <= ~pv;
			wr(ADDR_RSTCFG, 32'h0000_00FF);
			rd(ADDR_RSTCFG, d, r);
			chk(d, {24'h00_0000, pv}, "latch");
			rd(ADDR_STATUS, d, r);
			chk(32'(d[ST_DIV_BIT]), 32'(m), "mode");
			repeat (40) @(posedge aclk);
			base = len_q.size();
			repeat (60) @(posedge aclk);
			for (int i = base + 1; i < base + 5; i++) begin
				chk(32'(len_q[i]), 32'(m ? 8 : (lvl_q[i] ? 3 : 5)), "phase");
			end
			$display("test clock mode %0d done", m);
		end
		for (int k = 0; k < 8; k++) begin
			w = (k == 0) ? 4'hF : ((k == 7) ? 4'h0 : 4'($random(seed)));
			wrt = 1'($random(seed));
			cfg = {k[0], k[2], k[1], w};
			total = 6 + 2 * k[0] + 2 * (15 - w) + 2 * (1 - k[2]);
			wr(ADDR_BUSCFG, {25'h000_0000, cfg});
			rd(ADDR_BUSCFG, d, r);
			chk(d, {25'h000_0000, cfg}, "bus config");
			nd = -1;
			wr(ADDR_CTRL, {30'h0000_0000, wrt, 1'b1});
			rd(ADDR_CTRL, d, r);
			chk(32'(d[ST_BUSY_BIT]), 32'h0000_0001, "busy during cycle");
			// A second start while busy must be ignored
			wr(ADDR_CTRL, {30'h0000_0000, ~wrt, 1'b1});
			while (nd < 0) @(posedge aclk);
			@(posedge aclk);
			rd(ADDR_STATUS, d, r);
			chk(32'(d[15:8]), 32'(total), "cycle length");
			chk(32'(d[31:16]), 32'(k + 1), "cycle count");
			chk(32'(d[ST_BUSY_BIT]), 32'h0000_0000, "idle after cycle");
			chk(32'(nr - ns), 32'(3 + 2 * (15 - w) - k[1]), "strobe low time");
			chk(32'(nd - na), 32'(total - 1 - k[0]), "phases after latch");
			chk(32'(ns - na), 32'(k[0] + k[1]), "strobe start");
			chk(32'(wlow), 32'(wrt), "strobe kind");
			$display("test bus cycle %0d done", k);
		end
		wrap_up();
	end
endmodule
